// >>> ddi_ctl.sv
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`include "ddi_defines.svh"
// What this block does
// - Hold clock enable and termination low.
// - Run clock 200 us before anything.
// - Send NOP, then raise clock enable.
// - Wait 400 ns, then precharge all.
// - Write extended register two.
// - Write extended register three.
// - Write extended register one, DLL on.
// - Mode register write resetting the DLL.
// - Precharge all, then two refreshes.
// - Mode register write without DLL reset.
// - Calibration waits 200 clocks after reset.
// - Calibration default, then calibration exit.
// - Memory usable only after full sequence.
// - Wrong sequence gives undefined behaviour.
// - Keep termination pin low at power-up.
// - Registers hold the listed operating fields.
// - Every write carries all register fields.
// - Register writes keep array data intact.
// - Banks idle first, then wait after write.
// - Mode register field positions.
// - 200 clocks after DLL reset before reads.
module ddi_ctl
  import ddi_pkg::*;
#(
  parameter int STAB_CYC = `DDI_STAB_CYC,
  parameter int CK_DIV = `DDI_CK_DIV,
  parameter int TMRD_CK = `DDI_TMRD_CK,
  parameter int GAP_CK = `DDI_GAP_CK,
  parameter int RFC_CK = `DDI_RFC_CK
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  ddi_link_if.ctl lnk
);
  // Waits in system cycles, DLL_N in link clocks; one link period is two half periods of CK_DIV cycles.
  localparam logic [15:0] STAB_W = 16'(STAB_CYC);
  localparam logic [15:0] CKE_W = 16'(`DDI_CKE_CYC);
  localparam logic [15:0] MRD_W = 16'(TMRD_CK * 2 * CK_DIV);
  localparam logic [15:0] GAP_W = 16'(GAP_CK * 2 * CK_DIV);
  localparam logic [15:0] RFC_W = 16'(RFC_CK * 2 * CK_DIV);
  localparam logic [7:0] DLL_N = 8'(`DDI_DLL_CK);

  ddi_ctl_t q; // Registered state.
  ddi_ctl_t d; // Next state.
  logic ck_fall; // The link clock falls in this cycle.
  logic done; // The sequence has finished.

  assign done = (q.step == C_DONE);

  // Next-state logic: register port, clock divider and command sequencer.
  always_comb begin
    d = q;
    ck_fall = 1'b0;
    d.rdata = 32'h0000_0000;

    // The wait counter runs down on every system cycle.
    if (q.wait_cnt != 16'h0000) begin
      d.wait_cnt = q.wait_cnt - 16'h0001;
    end

    // The link clock is a plain divider, so it runs free from reset on.
    if (q.div == 4'(CK_DIV - 1)) begin
      d.div = 4'h0;
      d.ck = ~q.ck;
      ck_fall = q.ck;
    end else begin
      d.div = q.div + 4'h1;
    end

    // Register writes; values take effect when the next command using them goes out.
    if (reg_wr) begin
      case (reg_addr)
        `DDI_REG_CTRL: begin
          // A restart after completion leaves array data alone.
          if (done && reg_wdata[0]) begin
            d.step = C_CKE;
            d.wait_cnt = 16'h0000;
          end
        end
        `DDI_REG_MR: d.mr = reg_wdata[12:0];
        `DDI_REG_EMR1: d.emr1 = reg_wdata[12:0];
        `DDI_REG_EMR2: d.emr2 = reg_wdata[12:0];
        `DDI_REG_EMR3: d.emr3 = reg_wdata[12:0];
        default: d.mr = q.mr;
      endcase
    end

    // Reads answer in the next cycle; unmapped offsets read as zero.
    if (reg_rd) begin
      case (reg_addr)
        `DDI_REG_STAT: d.rdata = {24'h0, q.step, 2'h0, q.cke, done};
        `DDI_REG_MR: d.rdata = {19'h0, q.mr};
        `DDI_REG_EMR1: d.rdata = {19'h0, q.emr1};
        `DDI_REG_EMR2: d.rdata = {19'h0, q.emr2};
        `DDI_REG_EMR3: d.rdata = {19'h0, q.emr3};
        default: d.rdata = 32'h0000_0000;
      endcase
    end

    // Commands change on the falling link edge, half a period before the memory samples.
    if (ck_fall) begin
      // Every slot without a due command carries a NOP.
      d.cmd = `DDI_CMD_NOP;
      d.ba = 3'h0;
      d.a = 13'h0000;
      // Count link clocks since the DLL reset, saturating.
      if (q.dll_run && q.dll_cnt != DLL_N) begin
        d.dll_cnt = q.dll_cnt + 8'h01;
      end
      if (q.wait_cnt == 16'h0000) begin
        case (q.step)
          C_PWR: begin
            // NOP is already on the bus when clock enable rises.
            d.cke = 1'b1;
            // Only NOP for the clock-enable wait.
            d.wait_cnt = CKE_W;
            d.step = C_CKE;
          end
          C_CKE: begin
            d.cmd = `DDI_CMD_PRE;
            d.a[`DDI_A_PRE_ALL] = 1'b1;
            d.wait_cnt = GAP_W;
            d.step = C_EMR2;
          end
          C_EMR2: begin
            // Bank bits select extended register two.
            d.cmd = `DDI_CMD_MRS;
            d.ba = `DDI_BA_EMR2;
            d.a = q.emr2;
            d.wait_cnt = MRD_W;
            d.step = C_EMR3;
          end
          C_EMR3: begin
            // Bank bits select extended register three.
            d.cmd = `DDI_CMD_MRS;
            d.ba = `DDI_BA_EMR3;
            d.a = q.emr3;
            d.wait_cnt = MRD_W;
            d.step = C_EMR1;
          end
          C_EMR1: begin
            d.cmd = `DDI_CMD_MRS;
            d.ba = `DDI_BA_EMR1;
            d.a = q.emr1;
            d.a[`DDI_A_DLL_EN] = 1'b0;
            d.a[`DDI_A_OCD_HI:`DDI_A_OCD_LO] = `DDI_OCD_EXIT;
            d.wait_cnt = MRD_W;
            d.step = C_MRDLL;
          end
          C_MRDLL: begin
            // Mode register write with the DLL reset bit set.
            d.cmd = `DDI_CMD_MRS;
            d.ba = `DDI_BA_MR;
            d.a = q.mr;
            d.a[`DDI_A_DLL_RST] = 1'b1;
            // Test mode bit is always sent low.
            d.a[`DDI_A_TEST] = 1'b0;
            d.dll_run = 1'b1;
            d.dll_cnt = 8'h00;
            d.wait_cnt = MRD_W;
            d.step = C_PRE2;
          end
          C_PRE2: begin
            // Second precharge all, then the refresh pair.
            d.cmd = `DDI_CMD_PRE;
            d.a[`DDI_A_PRE_ALL] = 1'b1;
            d.ref_cnt = 2'h0;
            d.wait_cnt = GAP_W;
            d.step = C_REF;
          end
          C_REF: begin
            // Exactly the least number of refreshes is sent.
            d.cmd = `DDI_CMD_REF;
            d.ref_cnt = q.ref_cnt + 2'h1;
            d.wait_cnt = RFC_W;
            if (q.ref_cnt == 2'(`DDI_REF_N - 1)) begin
              d.step = C_MR;
            end
          end
          C_MR: begin
            // Operating parameters without another DLL reset.
            d.cmd = `DDI_CMD_MRS;
            d.ba = `DDI_BA_MR;
            d.a = q.mr;
            d.a[`DDI_A_DLL_RST] = 1'b0;
            d.a[`DDI_A_TEST] = 1'b0;
            d.wait_cnt = MRD_W;
            d.step = C_OCDDEF;
          end
          C_OCDDEF: begin
            // Calibration default is held back until the DLL count ends.
            if (q.dll_cnt == DLL_N) begin
              // Calibration default with the other fields of register one.
              d.cmd = `DDI_CMD_MRS;
              d.ba = `DDI_BA_EMR1;
              d.a = q.emr1;
              d.a[`DDI_A_DLL_EN] = 1'b0;
              d.a[`DDI_A_OCD_HI:`DDI_A_OCD_LO] = `DDI_OCD_DEFAULT;
              d.wait_cnt = MRD_W;
              d.step = C_OCDEXIT;
            end
          end
          C_OCDEXIT: begin
            // Calibration exit; the full word is sent again.
            d.cmd = `DDI_CMD_MRS;
            d.ba = `DDI_BA_EMR1;
            d.a = q.emr1;
            d.a[`DDI_A_DLL_EN] = 1'b0;
            d.a[`DDI_A_OCD_HI:`DDI_A_OCD_LO] = `DDI_OCD_EXIT;
            d.wait_cnt = MRD_W;
            d.step = C_DONE;
          end
          C_DONE: begin
            // Idle with NOP until software asks for a restart.
            d.step = C_DONE;
          end
          default: begin
            d.step = C_PWR;
          end
        endcase
      end
    end

    // Reset: clock enable low and stabilisation wait loaded.
    if (rst) begin
      d = '0;
      d.step = C_PWR;
      // The divider runs during this whole count.
      d.wait_cnt = STAB_W;
      d.cmd = `DDI_CMD_NOP;
      d.mr = `DDI_MR_RST;
      d.emr1 = `DDI_EMR_RST;
      d.emr2 = `DDI_EMR_RST;
      d.emr3 = `DDI_EMR_RST;
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    q <= d;
  end

  // Link pins other than termination come straight from the state register.
  assign lnk.ck = q.ck;
  // Clock enable stays low through the power-up wait.
  assign lnk.cke = q.cke;
  // Termination is never requested by this controller.
  assign lnk.odt = 1'b0;
  assign lnk.cs_n = q.cmd[3];
  assign lnk.ras_n = q.cmd[2];
  assign lnk.cas_n = q.cmd[1];
  assign lnk.we_n = q.cmd[0];
  assign lnk.ba = q.ba;
  assign lnk.a = q.a;
  assign reg_rdata = q.rdata;
endmodule

// >>> ddi_defines.svh
`ifndef DDI_DEFINES_SVH
`define DDI_DEFINES_SVH

// Command codes on {cs_n, ras_n, cas_n, we_n}.
`define DDI_CMD_MRS 4'h0
`define DDI_CMD_REF 4'h1
`define DDI_CMD_PRE 4'h2
`define DDI_CMD_ACT 4'h3
`define DDI_CMD_NOP 4'h7

// Bank address codes that select the mode and extended registers.
`define DDI_BA_MR 3'h0
`define DDI_BA_EMR1 3'h1
`define DDI_BA_EMR2 3'h2
`define DDI_BA_EMR3 3'h3

// Address bit positions.
`define DDI_A_DLL_EN 0
`define DDI_A_TEST 7
`define DDI_A_DLL_RST 8
`define DDI_A_PRE_ALL 10
`define DDI_A_OCD_LO 7
`define DDI_A_OCD_HI 9
`define DDI_OCD_DEFAULT 3'h7
`define DDI_OCD_EXIT 3'h0

// Timing: system clock, stabilisation, clock-enable wait, DLL lock.
`define DDI_CLK_MHZ 200
`define DDI_CLK_NS 5
`define DDI_T_STAB_US 200
`define DDI_STAB_CYC (`DDI_T_STAB_US * `DDI_CLK_MHZ)
`define DDI_T_CKE_NS 400
`define DDI_CKE_CYC ((`DDI_T_CKE_NS + `DDI_CLK_NS - 1) / `DDI_CLK_NS)
`define DDI_DLL_CK 200
`define DDI_REF_N 2
`define DDI_CK_DIV 4
`define DDI_TMRD_CK 2
`define DDI_GAP_CK 4
`define DDI_RFC_CK 16

// Controller register offsets and reset values.
`define DDI_REG_CTRL 8'h00
`define DDI_REG_STAT 8'h04
`define DDI_REG_MR 8'h08
`define DDI_REG_EMR1 8'h0C
`define DDI_REG_EMR2 8'h10
`define DDI_REG_EMR3 8'h14
`define DDI_MR_RST 13'h0000
`define DDI_EMR_RST 13'h0000

`endif

// >>> ddi_link_if.sv
`timescale 1ns/100ps
// Command and address link between the controller and the memory.
interface ddi_link_if;
  logic ck;
  logic cke;
  logic odt;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] ba;
  logic [12:0] a;
  modport ctl (output ck, cke, odt, cs_n, ras_n, cas_n, we_n, ba, a);
  modport mem (input ck, cke, odt, cs_n, ras_n, cas_n, we_n, ba, a);
endinterface

// >>> ddi_link_props.sv
`timescale 1ns/100ps
// Watches the link that joins the controller to the memory during power-up.
module ddi_link_props #(
  parameter int STAB_CYC = 40000,
  parameter int CK_DIV = 4,
  parameter int TMRD_CK = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ck,
  input wire logic cke,
  input wire logic odt,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [12:0] a
);
  // Minimum spacings in system clocks, one link period being two half periods.
  localparam int MRD_CYC = TMRD_CK * 2 * CK_DIV;
  localparam int DLL_CYC = 200 * 2 * CK_DIV;
  logic [3:0] cmd; // Command code as the memory decodes it.
  logic start; // High in the first cycle of a selected command.
  logic [2:0] exp_ba; // Bank code the next register write must carry.
  logic [3:0] cmd_q;
  logic [15:0] up_q; // Cycles since reset, saturating.
  logic [7:0] hi_q; // Cycles since clock enable rose, saturating.
  logic [7:0] gap_q; // Cycles since the last register write.
  logic [15:0] dll_q; // Cycles since the DLL reset write.
  logic [2:0] idx_q; // Register writes issued in this pass.
  logic [1:0] ref_q; // Refreshes since the last precharge or write.
  logic pre_q; // Banks known to be precharged.
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign start = (cmd != 4'h7) && (cmd_q == 4'h7) && !cs_n;
  assign exp_ba = (idx_q == 3'h0) ? 3'h2 : (idx_q == 3'h1) ? 3'h3 :
                  (idx_q == 3'h3 || idx_q == 3'h4) ? 3'h0 : 3'h1;

  // Counters track the pass; events come last so they win over the counting.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_q <= 4'h7;
      up_q <= 16'h0000;
      hi_q <= 8'h00;
      gap_q <= 8'hFF;
      dll_q <= 16'hFFFF;
      idx_q <= 3'h0;
      ref_q <= 2'h0;
      pre_q <= 1'b0;
    end else begin
      cmd_q <= cmd;
      if (up_q != 16'hFFFF) up_q <= up_q + 16'h0001;
      hi_q <= !cke ? 8'h00 : ((hi_q == 8'hFF) ? hi_q : hi_q + 8'h01);
      if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
      if (dll_q != 16'hFFFF) dll_q <= dll_q + 16'h0001;
      if (start && cmd == 4'h1 && ref_q != 2'h3) ref_q <= ref_q + 2'h1;
      // A precharge after a finished pass marks a restart.
      if (start && cmd == 4'h2 && a[10]) begin
        pre_q <= 1'b1;
        ref_q <= 2'h0;
        if (idx_q == 3'h7) idx_q <= 3'h0;
      end
      // The DLL reset write needs a fresh precharge before the next write.
      if (start && cmd == 4'h0) begin
        idx_q <= idx_q + 3'h1;
        gap_q <= 8'h00;
        ref_q <= 2'h0;
        if (idx_q == 3'h3) dll_q <= 16'h0000;
        if (idx_q == 3'h3) pre_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  odt_low_a: assert property (odt == 1'b0)
    else $error("termination driven high");
  stab_wait_a: assert property ($rose(cke) |-> up_q >= 16'(STAB_CYC - 1))
    else $error("clock enable rose too early");
  nop_idle_a: assert property (!cke |-> cmd == 4'h7)
    else $error("command while clock enable low");
  cke_settle_a: assert property (start |-> cke && hi_q >= 8'h50)
    else $error("command within 400 ns of clock enable");
  mrs_order_a: assert property (start && cmd == 4'h0 |-> ba == exp_ba)
    else $error("register write out of order");
  dll_bits_a: assert property (start && cmd == 4'h0 && ba == 3'h0 |->
    a[8] == (idx_q == 3'h3) && a[7] == 1'b0)
    else $error("bad DLL reset or test bit");
  ocd_bits_a: assert property (start && cmd == 4'h0 && ba == 3'h1 |->
    a[0] == 1'b0 && a[9:7] == ((idx_q == 3'h5) ? 3'h7 : 3'h0))
    else $error("bad DLL enable or calibration bits");
  refresh_pair_a: assert property (start && cmd == 4'h0 && idx_q == 3'h4 |-> ref_q >= 2'h2)
    else $error("fewer than two refreshes");
  banks_precharged_a: assert property (start && cmd == 4'h0 |-> pre_q)
    else $error("register write without precharge all");
  mrd_gap_a: assert property (start |-> gap_q >= 8'(MRD_CYC - 1))
    else $error("command inside register write cycle time");
  ocd_delay_a: assert property (start && cmd == 4'h0 && idx_q == 3'h5 |->
    dll_q >= 16'(DLL_CYC - 1))
    else $error("calibration too soon after DLL reset");
  known_cmd_a: assert property (start |-> cmd inside {4'h0, 4'h1, 4'h2})
    else $error("unexpected command during init");
  pins_on_fall_a: assert property ($changed(cmd) || $changed(a) || $changed(ba) |->
    $fell(ck))
    else $error("pins changed off a link clock fall");
endmodule

// >>> ddi_mem.sv
`timescale 1ns/100ps
`include "ddi_defines.svh"
// Memory end: follows the initialisation order and holds the mode registers.
module ddi_mem
  import ddi_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  ddi_link_if.mem lnk,
  output logic ready,
  output logic seq_err,
  output logic odt_on,
  output logic [12:0] mr,
  output logic [12:0] emr1,
  output logic [12:0] emr2,
  output logic [12:0] emr3
);
  ddi_mem_t q; // Registered state.
  ddi_mem_t d; // Next state.
  logic ck_rise; // Filtered rising edge of the link clock.
  logic cke; // Sampled clock enable.
  logic odt; // Sampled termination control.
  logic [3:0] cmd; // Sampled command code.
  logic [2:0] ba; // Sampled bank address.
  logic [12:0] a; // Sampled address.
  logic is_mrs; // Command is a register write.
  logic ok; // Command fits the expected step.

  // Pins are sampled late in the link period, so after three stages they are settled.
  assign cke = q.s3[21];
  assign odt = q.s3[20];
  assign cmd = q.s3[19:16];
  assign ba = q.s3[15:13];
  assign a = q.s3[12:0];
  assign is_mrs = (cmd == `DDI_CMD_MRS);

  // Next-state logic: synchroniser, edge filter and sequence follower.
  always_comb begin
    d = q;
    ck_rise = 1'b0;
    ok = 1'b1;
    d.s1 = {lnk.ck, lnk.cke, lnk.odt, lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n, lnk.ba, lnk.a};
    d.s2 = q.s1;
    d.s3 = q.s2;
    // A clock level counts only once the second and third stages agree.
    if (q.s2[22] == q.s3[22]) begin
      d.ck_f = q.s3[22];
      ck_rise = q.s3[22] & ~q.ck_f;
    end
    if (ck_rise) begin
      if (q.step == D_PWR) begin
        // Termination must stay low before the clock enable rises.
        if (odt) begin
          ok = 1'b0;
        end
        if (cke) begin
          d.step = D_NOP;
        end
      end else if (!q.s3[19] && cmd != `DDI_CMD_NOP) begin
        case (q.step)
          D_NOP: begin
            ok = (cmd == `DDI_CMD_PRE) && a[`DDI_A_PRE_ALL];
            d.step = D_EMR2;
          end
          D_EMR2: begin
            ok = is_mrs && ba == `DDI_BA_EMR2;
            d.step = D_EMR3;
          end
          D_EMR3: begin
            ok = is_mrs && ba == `DDI_BA_EMR3;
            d.step = D_EMR1;
          end
          D_EMR1: begin
            ok = is_mrs && ba == `DDI_BA_EMR1 && !a[`DDI_A_DLL_EN]
              && a[`DDI_A_OCD_HI:`DDI_A_OCD_LO] == `DDI_OCD_EXIT;
            d.step = D_MRDLL;
          end
          D_MRDLL: begin
            ok = is_mrs && ba == `DDI_BA_MR && a[`DDI_A_DLL_RST];
            d.step = D_PRE2;
          end
          D_PRE2: begin
            ok = (cmd == `DDI_CMD_PRE) && a[`DDI_A_PRE_ALL];
            d.ref_cnt = 2'h0;
            d.step = D_REF;
          end
          D_REF: begin
            if (cmd == `DDI_CMD_REF) begin
              if (q.ref_cnt != 2'h3) begin
                d.ref_cnt = q.ref_cnt + 2'h1;
              end
            end else begin
              ok = is_mrs && ba == `DDI_BA_MR && !a[`DDI_A_DLL_RST]
                && q.ref_cnt >= 2'(`DDI_REF_N);
              d.step = D_OCD1;
            end
          end
          D_OCD1: begin
            ok = is_mrs && ba == `DDI_BA_EMR1
              && a[`DDI_A_OCD_HI:`DDI_A_OCD_LO] == `DDI_OCD_DEFAULT;
            d.step = D_OCD2;
          end
          D_OCD2: begin
            ok = is_mrs && ba == `DDI_BA_EMR1
              && a[`DDI_A_OCD_HI:`DDI_A_OCD_LO] == `DDI_OCD_EXIT;
            d.step = D_READY;
          end
          D_READY: begin
            // Register writes in service keep the array and readiness.
            ok = 1'b1;
          end
          default: begin
            ok = 1'b0;
          end
        endcase
        // Register writes need all banks idle and clock enable high.
        if (is_mrs && (!q.banks_pre || !cke)) begin
          ok = 1'b0;
        end
        if (cmd == `DDI_CMD_PRE && a[`DDI_A_PRE_ALL]) begin
          d.banks_pre = 1'b1;
        end
        if (cmd == `DDI_CMD_ACT) begin
          d.banks_pre = 1'b0;
        end
        // The bank bits choose which register takes the word.
        if (is_mrs && ok) begin
          case (ba)
            `DDI_BA_MR: d.mr = a;
            `DDI_BA_EMR1: d.emr1 = a;
            `DDI_BA_EMR2: d.emr2 = a;
            `DDI_BA_EMR3: d.emr3 = a;
            default: d.mr = q.mr;
          endcase
        end
      end
      // Any departure from the order leaves the part unusable.
      if (!ok) begin
        d.err = 1'b1;
      end
      // Service is offered only after the whole sequence.
      d.ready = (d.step == D_READY) && !d.err;
      d.odt_on = d.ready && odt && (d.emr1[6] || d.emr1[2]);
    end
    if (rst) begin
      d = '0;
      d.step = D_PWR;
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    q <= d;
  end

  assign ready = q.ready;
  assign seq_err = q.err;
  assign odt_on = q.odt_on;
  assign mr = q.mr;
  assign emr1 = q.emr1;
  assign emr2 = q.emr2;
  assign emr3 = q.emr3;
endmodule

// >>> ddi_pkg.sv
`include "ddi_defines.svh"
package ddi_pkg;
  // Controller sequence steps.
  typedef enum logic [3:0] {
    C_PWR, C_CKE, C_EMR2, C_EMR3, C_EMR1, C_MRDLL, C_PRE2, C_REF, C_MR,
    C_OCDDEF, C_OCDEXIT, C_DONE
  } ddi_cstep_t;

  // Memory-side tracking steps.
  typedef enum logic [3:0] {
    D_PWR, D_NOP, D_EMR2, D_EMR3, D_EMR1, D_MRDLL, D_PRE2, D_REF, D_OCD1,
    D_OCD2, D_READY
  } ddi_dstep_t;

  // Complete controller state.
  typedef struct packed {
    ddi_cstep_t step;
    logic [15:0] wait_cnt;
    logic [7:0] dll_cnt;
    logic dll_run;
    logic [1:0] ref_cnt;
    logic [3:0] div;
    logic ck;
    logic cke;
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [12:0] a;
    logic [12:0] mr;
    logic [12:0] emr1;
    logic [12:0] emr2;
    logic [12:0] emr3;
    logic [31:0] rdata;
  } ddi_ctl_t;

  // Complete memory-side state.
  typedef struct packed {
    logic [22:0] s1;
    logic [22:0] s2;
    logic [22:0] s3;
    logic ck_f;
    ddi_dstep_t step;
    logic [12:0] mr;
    logic [12:0] emr1;
    logic [12:0] emr2;
    logic [12:0] emr3;
    logic [1:0] ref_cnt;
    logic banks_pre;
    logic ready;
    logic err;
    logic odt_on;
  } ddi_mem_t;
endpackage

// >>> ddr2_powerup_init_sequence_tb.sv
`timescale 1ns/100ps
`include "ddi_defines.svh"
// Runs power-up, a restart and a reset in mid-run; checks the link and memory.
module ddr2_powerup_init_sequence_tb;
  localparam int STAB = 200; // Shortened stabilisation wait.
  logic clk_sys;
  logic rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic ready;
  logic seq_err;
  logic odt_on;
  logic [12:0] mr_o;
  logic [12:0] e1_o;
  logic [12:0] e2_o;
  logic [12:0] e3_o;
  logic [31:0] seed; // Random source, fixed start.
  logic [12:0] sh [4]; // Values software put in MR, EMR1, EMR2, EMR3.
  logic [15:0] words [$]; // Register writes seen on the link, as {ba, a}.
  logic [3:0] cmd_q;
  int refs;
  int cyc;
  int failures;
  int compares;

  ddi_link_if ddi_link_if_i ();
  ddi_ctl #(.STAB_CYC(STAB)) ddi_ctl_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lnk(ddi_link_if_i));
  ddi_mem ddi_mem_i (.clk_sys(clk_sys), .rst(rst), .lnk(ddi_link_if_i), .ready(ready),
    .seq_err(seq_err), .odt_on(odt_on), .mr(mr_o), .emr1(e1_o), .emr2(e2_o), .emr3(e3_o));
  ddi_link_props #(.STAB_CYC(STAB), .CK_DIV(`DDI_CK_DIV), .TMRD_CK(`DDI_TMRD_CK))
    ddi_link_props_i (.clk_sys(clk_sys), .rst(rst), .ck(ddi_link_if_i.ck),
    .cke(ddi_link_if_i.cke), .odt(ddi_link_if_i.odt), .cs_n(ddi_link_if_i.cs_n),
    .ras_n(ddi_link_if_i.ras_n), .cas_n(ddi_link_if_i.cas_n), .we_n(ddi_link_if_i.we_n),
    .ba(ddi_link_if_i.ba), .a(ddi_link_if_i.a));

  // The system clock at 200 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Logs commands off the link and cuts a hang short.
  always @(posedge clk_sys) begin
    cyc++;
    cmd_q <= {ddi_link_if_i.cs_n, ddi_link_if_i.ras_n, ddi_link_if_i.cas_n, ddi_link_if_i.we_n};
    if (cmd_q == `DDI_CMD_NOP && !ddi_link_if_i.cs_n && ddi_link_if_i.ras_n == 1'b0) begin
      if (!ddi_link_if_i.cas_n && !ddi_link_if_i.we_n) words.push_back({ddi_link_if_i.ba,
        ddi_link_if_i.a});
      if (!ddi_link_if_i.cas_n && ddi_link_if_i.we_n) refs++;
    end
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected k-th register write of a pass, built from the software values.
  function automatic logic [15:0] exp_word(input int k);
    case (k)
      0: exp_word = {3'h2, sh[2]};
      1: exp_word = {3'h3, sh[3]};
      2: exp_word = {3'h1, sh[1] & 13'h1C7E};
      3: exp_word = {3'h0, (sh[0] | 13'h0100) & 13'h1F7F};
      4: exp_word = {3'h0, sh[0] & 13'h1E7F};
      5: exp_word = {3'h1, sh[1] | 13'h0380};
      default: exp_word = {3'h1, sh[1] & 13'h1C7E};
    endcase
  endfunction

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Link words are widened so that both kinds share one report format.
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    chk_val({16'h0, got}, {16'h0, exp});
  endtask

  task automatic reg_write(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic reg_read(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] d;
    reg_read(ad, d);
    chk_val(d, exp);
  endtask

  // Random register values with junk above bit 12; bit 0 kept low for DLL enable.
  task automatic prog();
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      sh[k] = seed[12:0] & 13'h1FFE;
      reg_write(8'(`DDI_REG_MR + 4 * k), {seed[31:13], sh[k]});
      rd_chk(8'(`DDI_REG_MR + 4 * k), {19'h0, sh[k]});
    end
  endtask

  // Polls the done bit, then lets the last command reach the memory.
  task automatic check_run();
    logic [31:0] d;
    d = 32'h0;
    while (d[0] !== 1'b1) reg_read(`DDI_REG_STAT, d);
    repeat (2 * `DDI_CK_DIV + 8) @(posedge clk_sys);
    chk_val({31'h0, ready}, 32'h1);
    chk_val({31'h0, seq_err}, 32'h0);
    chk_val({31'h0, odt_on}, 32'h0);
    chk_val(32'(words.size()), 32'h7);
    chk_val(32'(refs), 32'h2);
    foreach (words[k]) chk_word(words[k], exp_word(k));
    chk_val({19'h0, mr_o}, {19'h0, sh[0] & 13'h1E7F});
    chk_val({19'h0, e1_o}, {19'h0, sh[1] & 13'h1C7E});
    chk_val({19'h0, e2_o}, {19'h0, sh[2]});
    chk_val({19'h0, e3_o}, {19'h0, sh[3]});
    rd_chk(`DDI_REG_STAT, 32'h000000B3);
    words.delete();
    refs = 0;
  endtask

  task automatic end_of_test();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence: three passes, each ended by a full comparison.
  initial begin
    logic [31:0] d;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    seed = 32'h000033A6;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(`DDI_REG_STAT, 32'h0);
    reg_write(8'hFC, seed);
    rd_chk(8'hFC, 32'h0);
    rd_chk(`DDI_REG_CTRL, 32'h0);
    prog();
    rd_chk(`DDI_REG_STAT, 32'h0);
    reg_write(`DDI_REG_CTRL, 32'h1);
    check_run();
    // Restart with new values; the clock enable must stay high.
    prog();
    reg_write(`DDI_REG_CTRL, 32'h1);
    reg_read(`DDI_REG_STAT, d);
    chk_val({30'h0, d[1:0]}, 32'h2);
    check_run();
    // A reset in mid-pass starts everything over from the power-up state.
    reg_write(`DDI_REG_CTRL, 32'h1);
    repeat (300) @(posedge clk_sys);
    rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    words.delete();
    refs = 0;
    rd_chk(`DDI_REG_MR, 32'h0);
    prog();
    check_run();
    end_of_test();
  end
endmodule
